/* File: common/baud_gen_pkg.sv */
// Constants for the serial baud rate generator
`default_nettype none
package baud_gen_pkg;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 12;
    localparam logic [ADDR_W-1:0] BAUD_RATE_REGISTER_ADDR = 12'h000;
    localparam logic [DATA_W-1:0] BAUD_RATE_REGISTER_RESET = 32'h0000_0000;
    localparam int unsigned RATE_SEL_LSB = 0;
    localparam int unsigned RATE_SEL_W = 3;
    localparam int unsigned PRE_SEL_LSB = 4;
    localparam int unsigned PRE_SEL_W = 2;
    localparam int unsigned FIXED_DIV = 64;
    localparam int unsigned PRE_CNT_W = 4;
    localparam logic [PRE_CNT_W-1:0] PRE_DIV_00 = 4'h1;
    localparam logic [PRE_CNT_W-1:0] PRE_DIV_01 = 4'h3;
    localparam logic [PRE_CNT_W-1:0] PRE_DIV_10 = 4'h4;
    localparam logic [PRE_CNT_W-1:0] PRE_DIV_11 = 4'hd;
    localparam int unsigned RATE_CNT_W = 7;
endpackage
`default_nettype wire

/* File: hw/serial_baud_rate_generator.sv */
// Serial baud rate generator with its APB register
//
// How it works
// - Prescale field 00,01,10,11 selects divisor 1,3,4,13.
// - Rate field value n selects divisor two to the n.
// - Enable rate is the input clock over 64 times both divisors.
// - Rate field reads back, written by software, zero after reset.
// - Prescale field is zero after reset, so divisor starts at one.
// - One enable drives both receiver and transmitter.
`timescale 1ns/1ns
`default_nettype none
module serial_baud_rate_generator
    import baud_gen_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [baud_gen_pkg::ADDR_W-1:0] paddr,
    input wire logic [baud_gen_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [baud_gen_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic baud_tick
);
    import baud_gen_pkg::*;

    // ------------------------------------------------------------
    // Divisor decoding
    // ------------------------------------------------------------
    function automatic logic [PRE_CNT_W-1:0] prescaler_divisor(input logic [PRE_SEL_W-1:0] s);
        case (s)
            2'b00: prescaler_divisor = PRE_DIV_00;
            2'b01: prescaler_divisor = PRE_DIV_01;
            2'b10: prescaler_divisor = PRE_DIV_10;
            default: prescaler_divisor = PRE_DIV_11;
        endcase
    endfunction

    // Terminal count of the power-of-two stage is 2^n - 1
    function automatic logic [RATE_CNT_W-1:0] rate_last(input logic [RATE_SEL_W-1:0] s);
        rate_last = RATE_CNT_W'((1 << s) - 1);
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [RATE_SEL_W-1:0] rate_divider_select_field;
        logic [PRE_SEL_W-1:0] prescale_select_field;
        logic [5:0] fixed_cnt;
        logic [PRE_CNT_W-1:0] pre_cnt;
        logic [RATE_CNT_W-1:0] rate_cnt;
        logic tick;
        logic [DATA_W-1:0] rdata;
        logic ready;
        logic err;
    } state_s;

    state_s state_r;
    state_s state_nxt;
    logic fixed_wrap;
    logic pre_wrap;
    logic rate_wrap;
    logic hit;
    logic [DATA_W-1:0] reg_view;

    assign hit = (paddr == BAUD_RATE_REGISTER_ADDR);
    assign fixed_wrap = (state_r.fixed_cnt == 6'(FIXED_DIV - 1));
    assign pre_wrap = (state_r.pre_cnt == prescaler_divisor(state_r.prescale_select_field) - 4'h1);
    assign rate_wrap = (state_r.rate_cnt == rate_last(state_r.rate_divider_select_field));

    // ------------------------------------------------------------
    // Register view
    // ------------------------------------------------------------
    always_comb
    begin
        reg_view = '0;
        reg_view[RATE_SEL_LSB +: RATE_SEL_W] = state_r.rate_divider_select_field;
        reg_view[PRE_SEL_LSB +: PRE_SEL_W] = state_r.prescale_select_field;
    end

    // ------------------------------------------------------------
    // Divider cascade and bus answer
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        state_nxt.tick = 1'b0;
        state_nxt.ready = 1'b0;
        state_nxt.err = 1'b0;
        // Cascade: 64, then prescaler, then power of two
        state_nxt.fixed_cnt = fixed_wrap ? 6'h0 : 6'(state_r.fixed_cnt + 6'h1);
        if (fixed_wrap)
        begin
            state_nxt.pre_cnt = pre_wrap ? '0 : PRE_CNT_W'(state_r.pre_cnt + 4'h1);
            if (pre_wrap)
            begin
                state_nxt.rate_cnt = rate_wrap ? '0 : RATE_CNT_W'(state_r.rate_cnt + 7'h1);
                state_nxt.tick = rate_wrap;
            end
        end
        // Single-wait-state APB slave: answer one cycle into access phase
        if (psel && penable && !state_r.ready)
        begin
            state_nxt.ready = 1'b1;
            state_nxt.err = !hit;
            state_nxt.rdata = (hit && !pwrite) ? reg_view : '0;
            if (hit && pwrite && pstrb[0])
            begin
                state_nxt.rate_divider_select_field = pwdata[RATE_SEL_LSB +: RATE_SEL_W];
                state_nxt.prescale_select_field = pwdata[PRE_SEL_LSB +: PRE_SEL_W];
                // Restart the divider so a new rate takes effect cleanly
                state_nxt.fixed_cnt = '0;
                state_nxt.pre_cnt = '0;
                state_nxt.rate_cnt = '0;
                state_nxt.tick = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Straight from the state register, so no glitch reaches the shift logic
    assign prdata = state_r.rdata;
    assign pready = state_r.ready;
    assign pslverr = state_r.err;
    assign baud_tick = state_r.tick;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Write that the register takes; the same edge restarts the cascade
    logic wr_take;
    assign wr_take = psel && penable && !state_r.ready && hit && pwrite && pstrb[0];

    // Cycles since the cascade last stood at zero; wide enough for 64 x 13 x 128
    logic [16:0] gap_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gap_r <= '0;
        else if (state_nxt.tick || wr_take)
            gap_r <= '0;
        else
            gap_r <= 17'(gap_r + 17'h0_0001);
    end

    // Divisors spelled out again, kept apart from the decode function
    logic [31:0] pd_doc;
    logic [31:0] bd_doc;
    always_comb
    begin
        case (state_r.prescale_select_field)
            2'b00: pd_doc = 32'(PRE_DIV_00);
            2'b01: pd_doc = 32'(PRE_DIV_01);
            2'b10: pd_doc = 32'(PRE_DIV_10);
            default: pd_doc = 32'(PRE_DIV_11);
        endcase
        bd_doc = 32'h0000_0001 << state_r.rate_divider_select_field;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    fastest_rate_a: assert property (
        state_r.prescale_select_field == 2'b00 && state_r.rate_divider_select_field == 3'b000
        && fixed_wrap && !wr_take |=> baud_tick)
        else $error("no tick at end of 64 cycles at divisor one");
    tick_pulse_a: assert property (baud_tick |=> !baud_tick)
        else $error("tick longer than one cycle");
    tick_period_a: assert property (
        baud_tick |-> 32'($past(gap_r)) + 32'h0000_0001 == 32'(FIXED_DIV) * pd_doc * bd_doc)
        else $error("tick period differs from divisor product");
    pre_decode_a: assert property (
        fixed_wrap && pre_wrap |-> 32'(state_r.pre_cnt) + 32'h0000_0001 == pd_doc)
        else $error("prescaler stage wraps at wrong count");
    rate_decode_a: assert property (
        fixed_wrap && pre_wrap && rate_wrap |-> 32'(state_r.rate_cnt) + 32'h0000_0001 == bd_doc)
        else $error("rate stage wraps at wrong count");
    cnt_bound_a: assert property (
        32'(state_r.pre_cnt) < pd_doc && 32'(state_r.rate_cnt) < bd_doc)
        else $error("divider stage count past its divisor");
    write_store_a: assert property (
        wr_take
        |=> state_r.rate_divider_select_field == $past(pwdata[RATE_SEL_LSB +: RATE_SEL_W])
        && state_r.prescale_select_field == $past(pwdata[PRE_SEL_LSB +: PRE_SEL_W]))
        else $error("register fields not stored");
    rate_hold_a: assert property (
        !wr_take |=> $stable(state_r.rate_divider_select_field)
        && $stable(state_r.prescale_select_field))
        else $error("register fields changed without a write");
    read_back_a: assert property (
        psel && penable && !pready && !pwrite && hit
        |=> pready && prdata[RATE_SEL_LSB +: RATE_SEL_W] == state_r.rate_divider_select_field
        && prdata[PRE_SEL_LSB +: PRE_SEL_W] == state_r.prescale_select_field)
        else $error("register read mismatch");
    reset_zero_a: assert property (
        $rose(presetn) |-> state_r.prescale_select_field == 2'b00
        && state_r.rate_divider_select_field == 3'b000)
        else $error("register fields not cleared by reset");
    unmapped_err_a: assert property (psel && penable && !pready && !hit |=> pslverr)
        else $error("unmapped access not flagged");
    err_pair_a: assert property (pslverr |-> pready)
        else $error("error flag without ready");

    // ------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------
    tick_seen_c: cover property (baud_tick);
    slow_rate_c: cover property (state_r.prescale_select_field == 2'b11 && baud_tick);
    write_c: cover property (pready && pwrite && hit);
    error_c: cover property (pslverr);
    restart_c: cover property (wr_take && state_r.prescale_select_field != 2'b00);
endmodule
`default_nettype wire

/* File: sim/serial_baud_rate_generator_test.sv */
// Self-checking bench for the baud rate generator
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) total_checks++; if ((a) !== (b)) begin err_count++; \
    $display("wrong value t=%0t got %h exp %h", $time, a, b); end
module serial_baud_rate_generator_test;
    import baud_gen_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, baud_tick;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd, gap, ticks, n;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] rows [11][2];
    int err_count = 0, total_checks = 0, cyc = 0;
    logic er;
    serial_baud_rate_generator uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .baud_tick(baud_tick));
    shift_logic_model far (.pclk(pclk), .presetn(presetn), .baud_tick(baud_tick),
        .gap(gap), .ticks(ticks));
    always #25 pclk = ~pclk;
    // All row pairs together need about 35k cycles
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            err_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    initial
    begin
        for (int i = 0; i < 8; i++)
            rows[i] = '{32'(i), 32'h0000_0040 << i};
        rows[8] = '{32'h0000_0010, 32'h0000_00c0};
        rows[9] = '{32'h0000_0020, 32'h0000_0100};
        rows[10] = '{32'h0000_0030, 32'h0000_0340};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0000_0000, 4'h0);
        `CHK(rd, 32'h0000_0000)
        for (int i = 0; i < 11; i++)
        begin
            apb(1'b1, 12'h000, rows[i][0], 4'hf);
            apb(1'b0, 12'h000, 32'h0000_0000, 4'h0);
            `CHK(rd, rows[i][0])
            `CHK(er, 1'b0)
            n = ticks;
            while (ticks < n + 2) @(posedge pclk);
            `CHK(gap, rows[i][1])
        end
        // Reserved bits, disabled strobe and unmapped address
        apb(1'b1, 12'h000, 32'hffff_ffff, 4'hf);
        apb(1'b1, 12'h000, 32'h0000_0000, 4'h0);
        apb(1'b0, 12'h000, 32'h0000_0000, 4'h0);
        `CHK(rd, 32'h0000_0037)
        apb(1'b0, 12'h004, 32'h0000_0000, 4'h0);
        `CHK({er, rd}, 33'h1_0000_0000)
        // Reset in mid-run clears both fields
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0000_0000, 4'h0);
        `CHK(rd, 32'h0000_0000)
        n = ticks;
        while (ticks < n + 2) @(posedge pclk);
        `CHK(gap, 32'h0000_0040)
        stop_test();
    end
endmodule
`default_nettype wire

/* File: sim/shift_logic_model.sv */
// Far-side shift logic model: times the shared rate enable
`timescale 1ns/1ns
`default_nettype none
module shift_logic_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic baud_tick,
    output logic [31:0] gap,
    output logic [31:0] ticks
);
    logic [31:0] cnt_r;
    // Receiver and transmitter step on one enable, so one count serves both
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r <= 32'h0000_0001;
            gap <= 32'h0000_0000;
            ticks <= 32'h0000_0000;
        end
        else if (baud_tick)
        begin
            gap <= cnt_r;
            ticks <= ticks + 32'h0000_0001;
            cnt_r <= 32'h0000_0001;
        end
        else
        begin
            cnt_r <= cnt_r + 32'h0000_0001;
        end
    end
endmodule
`default_nettype wire
